// ==== pkg/mos_pkg.sv ====
// shared types and constants for the marker output selector
package mos_pkg;

  // waveform sample address width
  localparam int unsigned ADDR_W          = 16;
  // number of leading arbitrary addresses flagged by the phase marker
  localparam logic [15:0] ARB_MARK_POINTS = 16'h0004;
  // serial character width and flow-control characters
  localparam int unsigned CHAR_W          = 8;
  localparam logic [7:0]  CHAR_XON        = 8'h11;
  localparam logic [7:0]  CHAR_XOFF       = 8'h13;
  // address characters carry this mark in the top bit, address in the rest
  localparam logic [7:0]  ADDR_CHAR_MARK  = 8'h80;
  localparam logic [7:0]  ADDR_CHAR_MASK  = 8'h7F;
  // reset values
  localparam logic        MARK_RESET      = 1'b0;
  localparam logic        TX_IDLE         = 1'b1;
  localparam logic        TX_PERMIT_RESET = 1'b1;

  // marker source choices
  typedef enum logic [2:0] {
    MOS_SRC_PHASE,
    MOS_SRC_POSITION,
    MOS_SRC_BURST,
    MOS_SRC_SEQUENCE,
    MOS_SRC_TRIGGER,
    MOS_SRC_SWEEP,
    MOS_SRC_LOCK
  } mos_src_t;

  // reference socket modes
  typedef enum logic [1:0] {
    MOS_REF_INPUT,
    MOS_REF_OUTPUT,
    MOS_REF_LOCK_MASTER,
    MOS_REF_LOCK_SLAVE
  } mos_ref_t;

  // role of the external trigger input
  typedef enum logic [1:0] {
    MOS_TRIG_EVENT,
    MOS_TRIG_GATE,
    MOS_TRIG_SWEEP,
    MOS_TRIG_SEQUENCE
  } mos_trig_t;

  // serial port operating modes
  typedef enum logic {
    MOS_SER_PLAIN,
    MOS_SER_ADDRESSED
  } mos_ser_t;

endpackage

// ==== hdl/mos_serial_port.sv ====
// serial line routing, xon/xoff flow control and address matching
`timescale 1ns/1ps
module mos_serial_port
  import mos_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // configuration
  input  wire mos_ser_t          serMode,
  input  wire logic [6:0]        serAddress,
  // line pins
  input  wire logic              primarySerialReceive,
  input  wire logic              secondarySerialReceive,
  output logic                   primarySerialTransmit,
  output logic                   secondarySerialTransmit,
  // character side
  input  wire logic              txLine,
  output logic                   rxLine,
  input  wire logic [CHAR_W-1:0] rxChar,
  input  wire logic              rxCharValid,
  output logic                   txPermit,
  output logic                   addressed
);

  logic [1:0] priSync;
  logic [1:0] secSync;
  logic       addrMode;
  logic       isAddrChar;
  logic       addrHit;
  logic       next_txPermit;
  logic       next_addressed;

  // two stages on each receive pin; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      priSync <= {2{TX_IDLE}};
      secSync <= {2{TX_IDLE}};
    end else begin
      priSync <= {priSync[0], primarySerialReceive};
      secSync <= {secSync[0], secondarySerialReceive};
    end
  end

  assign addrMode   = (serMode == MOS_SER_ADDRESSED);
  assign rxLine     = addrMode ? secSync[1] : priSync[1];
  assign isAddrChar = addrMode && ((rxChar & ADDR_CHAR_MARK) == ADDR_CHAR_MARK);
  assign addrHit    = ((rxChar & ADDR_CHAR_MASK) == {1'b0, serAddress});

  // flow characters only count on the active line; xoff pauses, xon resumes
  assign next_txPermit = !rxCharValid           ? txPermit :
                         (rxChar == CHAR_XOFF)  ? 1'b0 :
                         (rxChar == CHAR_XON)   ? 1'b1 : txPermit;
  // an address character selects or deselects this unit
  assign next_addressed = !addrMode                  ? 1'b1 :
                          (rxCharValid && isAddrChar) ? addrHit : addressed;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txPermit  <= TX_PERMIT_RESET;
      addressed <= 1'b0;
    end else begin
      txPermit  <= next_txPermit;
      addressed <= next_addressed;
    end
  end

  // unused line idles high; in addressed mode speak only when selected
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      primarySerialTransmit   <= TX_IDLE;
      secondarySerialTransmit <= TX_IDLE;
    end else begin
      primarySerialTransmit   <= addrMode ? TX_IDLE : txLine;
      secondarySerialTransmit <= (addrMode && addressed) ? txLine : TX_IDLE;
    end
  end

endmodule

// ==== hdl/mos_marker_output_selector.sv ====
// per-channel marker source selection with socket, trigger, hold and serial control
// How it works
// - marker driven by one user-selected source
// - standard phase marker: square, rising zero, falling half
// - arbitrary phase marker: pulse over first addresses
// - position source plays stored per-address pattern
// - position on standard wave: one-sample cycle-start pulse
// - burst source low while waveform active in gated or triggered mode
// - sequence source low during last final cycle
// - trigger source gives positive trigger pulse
// - every trigger origin produces trigger marker
// - sweep source high from sweep start to end
// - lock source rises at waveform start
// - reference input default, auto switch to external
// - output mode drives internal reference onto socket
// - one lock master, all others lock slave
// - trigger input serves all roles and lock
// - hold input freezes waveform output
// - cursor pulse marks sweep or edit position
// - primary serial lines with xon/xoff control
// - addressed mode uses secondary lines and address
// - master marker feeds slave trigger for locking
`timescale 1ns/1ps
module mos_marker_output_selector
  import mos_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // user settings
  input  wire mos_src_t          markSource,
  input  wire mos_ref_t          refMode,
  input  wire mos_trig_t         trigRole,
  input  wire logic              gatedOrTriggered,
  // waveform engine state
  input  wire logic              sampleEn,
  input  wire logic              waveIsArb,
  input  wire logic              phaseUpperHalf,
  input  wire logic [ADDR_W-1:0] sampleAddr,
  input  wire logic              cycleStart,
  input  wire logic              patternBit,
  input  wire logic              waveActive,
  input  wire logic              lastSeqCycle,
  input  wire logic              sweepBegin,
  input  wire logic              sweepEnd,
  // trigger origins and the front-panel hold key
  input  wire logic              internalTrig,
  input  wire logic              manualTrig,
  input  wire logic              remoteTrig,
  input  wire logic              manualHold,
  // pins from outside the clock domain
  input  wire logic              external_trigger_input,
  input  wire logic              holdIn,
  input  wire logic              extRefPresent,
  // cursor sources
  input  wire logic              sweepPosHit,
  input  wire logic              editing,
  input  wire logic              editCursorHit,
  // serial pins and character side
  input  wire mos_ser_t          serMode,
  input  wire logic [6:0]        serAddress,
  input  wire logic              primarySerialReceive,
  input  wire logic              secondary_serial_receive,
  output logic                   primarySerialTransmit,
  output logic                   secondary_serial_transmit,
  input  wire logic              txLine,
  output logic                   rxLine,
  input  wire logic [CHAR_W-1:0] rxChar,
  input  wire logic              rxCharValid,
  output logic                   txPermit,
  output logic                   addressed,
  // marker and cursor outputs
  output logic                   markerOut,
  output logic                   cursorOut,
  // reference socket control
  output logic                   useExternalRef,
  output logic                   refSocketOe,
  output logic                   refSocketOut,
  // decoded trigger input roles
  output logic                   extTrigEvent,
  output logic                   extGate,
  output logic                   extSweepStart,
  output logic                   extSeqAdvance,
  output logic                   lockRestart,
  // hold control to the waveform engine
  output logic                   waveHold
);

  // synchronisers: stage one is read only by stage two
  logic [1:0] trigSync;
  logic [1:0] holdSync;
  logic [1:0] refSync;
  logic       trigPrev;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trigSync <= 2'h0;
      holdSync <= 2'h0;
      refSync  <= 2'h0;
    end else begin
      trigSync <= {trigSync[0], external_trigger_input};
      holdSync <= {holdSync[0], holdIn};
      refSync  <= {refSync[0], extRefPresent};
    end
  end

  // edge detect works on the second stage only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trigPrev <= 1'b0;
    end else begin
      trigPrev <= trigSync[1];
    end
  end

  logic extTrigRise;
  logic isLockSlave;
  logic isLockMaster;
  assign extTrigRise  = trigSync[1] && !trigPrev;
  assign isLockSlave  = (refMode == MOS_REF_LOCK_SLAVE);
  assign isLockMaster = (refMode == MOS_REF_LOCK_MASTER);

  // trigger input roles; as a lock slave the input carries the master edge
  logic next_extTrigEvent;
  logic next_extGate;
  logic next_extSweepStart;
  logic next_extSeqAdvance;
  logic next_lockRestart;
  assign next_extTrigEvent  = !isLockSlave && extTrigRise && (trigRole == MOS_TRIG_EVENT);
  assign next_extGate       = !isLockSlave && trigSync[1] && (trigRole == MOS_TRIG_GATE);
  assign next_extSweepStart = !isLockSlave && extTrigRise && (trigRole == MOS_TRIG_SWEEP);
  assign next_extSeqAdvance = !isLockSlave && extTrigRise
                              && (trigRole == MOS_TRIG_SEQUENCE);
  assign next_lockRestart   = isLockSlave && extTrigRise;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      extTrigEvent  <= 1'b0;
      extGate       <= 1'b0;
      extSweepStart <= 1'b0;
      extSeqAdvance <= 1'b0;
      lockRestart   <= 1'b0;
    end else begin
      extTrigEvent  <= next_extTrigEvent;
      extGate       <= next_extGate;
      extSweepStart <= next_extSweepStart;
      extSeqAdvance <= next_extSeqAdvance;
      lockRestart   <= next_lockRestart;
    end
  end

  // hold from the pin or the front-panel key pauses the engine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waveHold <= 1'b0;
    end else begin
      waveHold <= holdSync[1] || manualHold;
    end
  end

  // reference socket: input mode by default, external taken when present
  logic next_useExternalRef;
  logic next_refSocketOe;
  assign next_useExternalRef = ((refMode == MOS_REF_INPUT) || isLockSlave) && refSync[1];
  // master drives its reference out for the slaves to follow
  assign next_refSocketOe    = (refMode == MOS_REF_OUTPUT) || isLockMaster;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      useExternalRef <= 1'b0;
      refSocketOe    <= 1'b0;
    end else begin
      useExternalRef <= next_useExternalRef;
      refSocketOe    <= next_refSocketOe;
    end
  end
  // the clock itself cannot pass through a flip-flop; the pad buffer routes it
  assign refSocketOut = refSocketOe;

  // one-sample pulse at each cycle start, also the lock edge source
  logic cyclePulse;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyclePulse <= 1'b0;
    end else if (sampleEn && !waveHold) begin
      cyclePulse <= cycleStart;
    end
  end

  // sweep span flag; a begin in the same cycle as an end wins
  logic sweepSpan;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sweepSpan <= 1'b0;
    end else if (sweepBegin) begin
      sweepSpan <= 1'b1;
    end else if (sweepEnd) begin
      sweepSpan <= 1'b0;
    end
  end

  // any trigger origin, including an external trigger event
  logic anyTrig;
  assign anyTrig = internalTrig || manualTrig || remoteTrig || next_extTrigEvent;

  // candidate levels for the phase, position, burst, sequence and lock sources
  logic phaseMark;
  logic posMark;
  logic burstMark;
  logic seqMark;
  logic lockMark;
  assign phaseMark = waveIsArb ? (sampleAddr < ARB_MARK_POINTS)
                               : !phaseUpperHalf;
  assign posMark   = waveIsArb ? patternBit : cyclePulse;
  assign burstMark = gatedOrTriggered ? !waveActive : 1'b1;
  assign seqMark   = !lastSeqCycle;
  assign lockMark  = cyclePulse;

  // selection is a plain mux; the output flop removes any decode glitch
  logic next_markerOut;
  always_comb begin
    next_markerOut = MARK_RESET;
    unique case (markSource)
      MOS_SRC_PHASE:    next_markerOut = phaseMark;
      MOS_SRC_POSITION: next_markerOut = posMark;
      MOS_SRC_BURST:    next_markerOut = burstMark;
      MOS_SRC_SEQUENCE: next_markerOut = seqMark;
      MOS_SRC_TRIGGER:  next_markerOut = anyTrig;
      MOS_SRC_SWEEP:    next_markerOut = sweepSpan;
      MOS_SRC_LOCK:     next_markerOut = lockMark;
      default:          next_markerOut = MARK_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      markerOut <= MARK_RESET;
    end else begin
      markerOut <= next_markerOut;
    end
  end

  // cursor: sweep position during sweeps, edit cursor while editing an arbitrary wave
  logic next_cursorOut;
  assign next_cursorOut = (sweepSpan && sweepPosHit)
                          || (editing && waveIsArb && editCursorHit);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cursorOut <= 1'b0;
    end else begin
      cursorOut <= next_cursorOut;
    end
  end

  // remote serial port
  mos_serial_port u_serial (
    .ref_clk                 (ref_clk),
    .arst_n                  (arst_n),
    .serMode                 (serMode),
    .serAddress              (serAddress),
    .primarySerialReceive    (primarySerialReceive),
    .secondarySerialReceive  (secondary_serial_receive),
    .primarySerialTransmit   (primarySerialTransmit),
    .secondarySerialTransmit (secondary_serial_transmit),
    .txLine                  (txLine),
    .rxLine                  (rxLine),
    .rxChar                  (rxChar),
    .rxCharValid             (rxCharValid),
    .txPermit                (txPermit),
    .addressed               (addressed)
  );

endmodule

// ==== tb/mos_marker_output_selector_monitor.sv ====
// port assertions for the marker output selector
`timescale 1ns/1ps
module mos_mon
  import mos_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              arst_n,
  // settings and engine state
  input wire mos_src_t          markSource,
  input wire logic              waveIsArb,
  input wire logic              phaseUpperHalf,
  input wire logic [ADDR_W-1:0] sampleAddr,
  input wire logic              patternBit,
  input wire logic              lastSeqCycle,
  input wire logic              internalTrig,
  input wire logic              manualTrig,
  input wire logic              remoteTrig,
  input wire logic              manualHold,
  input wire logic [CHAR_W-1:0] rxChar,
  input wire logic              rxCharValid,
  // watched outputs
  input wire logic              markerOut,
  input wire logic              waveHold,
  input wire logic              txPermit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire trigSel = markSource == MOS_SRC_TRIGGER;
  wire phaseSel = markSource == MOS_SRC_PHASE;
  wire posSel = markSource == MOS_SRC_POSITION;
  property p_trig; trigSel && internalTrig |=> markerOut; endproperty
  a_trig: assert property (p_trig) else $error("internal trigger gave no marker");
  property p_orig; trigSel && (manualTrig || remoteTrig) |-> ##1 markerOut; endproperty
  a_orig: assert property (p_orig) else $error("manual or remote trigger lost");
  property p_seq; markSource == MOS_SRC_SEQUENCE |=> markerOut == !$past(lastSeqCycle); endproperty
  a_seq: assert property (p_seq) else $error("sequence marker wrong");
  property p_arb; phaseSel && waveIsArb |=> markerOut == ($past(sampleAddr) < ARB_MARK_POINTS); endproperty
  a_arb: assert property (p_arb) else $error("arbitrary phase marker wrong");
  property p_std; phaseSel && !waveIsArb |=> markerOut != $past(phaseUpperHalf); endproperty
  a_std: assert property (p_std) else $error("standard phase marker wrong");
  property p_pos; posSel && waveIsArb |=> markerOut == $past(patternBit); endproperty
  a_pos: assert property (p_pos) else $error("position pattern not followed");
  property p_hold; manualHold [*2] |-> waveHold; endproperty
  a_hold: assert property (p_hold) else $error("manual hold not applied");
  property p_xoff; rxCharValid && rxChar == CHAR_XOFF |=> !txPermit; endproperty
  a_xoff: assert property (p_xoff) else $error("stop character ignored");
  c_trig: cover property (trigSel && internalTrig ##1 markerOut);
  c_xoff: cover property (rxCharValid && rxChar == CHAR_XOFF);
  c_arb: cover property (phaseSel && waveIsArb && sampleAddr == ARB_MARK_POINTS);
endmodule
bind mos_marker_output_selector mos_mon i_mon (.ref_clk, .arst_n, .markSource, .waveIsArb,
  .phaseUpperHalf, .sampleAddr, .patternBit, .lastSeqCycle, .internalTrig, .manualTrig,
  .remoteTrig, .manualHold, .rxChar, .rxCharValid, .markerOut, .waveHold, .txPermit);

// ==== tb/mos_far_side.sv ====
// far-side master generator and host pins
`timescale 1ns/1ps
module mos_far_side (
  // clock
  input wire logic ref_clk,
  // pins toward the channel
  output logic     external_trigger_input,
  output logic     holdIn,
  output logic     extRefPresent,
  output logic     primarySerialReceive,
  output logic     secondary_serial_receive
);
  // no frames are sent, so the serial lines rest at their idle high
  initial begin
    external_trigger_input = 1'h0;
    holdIn = 1'h0;
    extRefPresent = 1'h0;
    primarySerialReceive = 1'h1;
    secondary_serial_receive = 1'h1;
  end
  // lock edge held n cycles so the slave's sync flops cannot miss it
  task automatic pulse(input int n);
    @(posedge ref_clk) external_trigger_input <= 1'h1;
    repeat (n) @(posedge ref_clk);
    external_trigger_input <= 1'h0;
  endtask
  task automatic set_rx(input logic p, input logic s);
    @(posedge ref_clk) primarySerialReceive <= p;
    secondary_serial_receive <= s;
  endtask
  task automatic set_pins(input logic h, input logic r);
    @(posedge ref_clk) holdIn <= h;
    extRefPresent <= r;
  endtask
endmodule

// ==== tb/test_marker_output_selector.sv ====
// self-checking bench for the marker output selector
`timescale 1ns/1ps
module test_marker_output_selector
  import mos_pkg::*;
;
  logic ref_clk = 1'h0, arst_n = 1'h0;
  mos_src_t markSource = MOS_SRC_PHASE;
  mos_ref_t refMode = MOS_REF_INPUT;
  mos_trig_t trigRole = MOS_TRIG_EVENT;
  mos_ser_t serMode = MOS_SER_PLAIN;
  logic gatedOrTriggered = 1'h0, sampleEn = 1'h0, waveIsArb = 1'h0, phaseUpperHalf = 1'h0;
  logic cycleStart = 1'h0, patternBit = 1'h0, waveActive = 1'h0, lastSeqCycle = 1'h0;
  logic sweepBegin = 1'h0, sweepEnd = 1'h0, internalTrig = 1'h0, manualTrig = 1'h0;
  logic remoteTrig = 1'h0, manualHold = 1'h0, sweepPosHit = 1'h0, editing = 1'h0;
  logic editCursorHit = 1'h0, txLine = 1'h1, rxCharValid = 1'h0;
  logic [ADDR_W-1:0] sampleAddr = 16'h0000;
  logic [6:0] serAddress = 7'h05;
  logic [CHAR_W-1:0] rxChar = 8'h00;
  logic external_trigger_input, holdIn, extRefPresent, primarySerialReceive, rxLine;
  logic secondary_serial_receive, primarySerialTransmit, secondary_serial_transmit;
  logic txPermit, addressed, markerOut, cursorOut, useExternalRef, refSocketOe, refSocketOut;
  logic extTrigEvent, extGate, extSweepStart, extSeqAdvance, lockRestart, waveHold;
  int n_fail = 0, comparisons = 0, cM, cE, cG, cS, cQ, cL;
  logic [31:0] r;
  logic expM, swSt = 1'h0;
  bit rndOn = 1'h0, have = 1'h0;
  always #50 ref_clk = ~ref_clk;
  mos_far_side i_far (.ref_clk, .external_trigger_input, .holdIn, .extRefPresent,
    .primarySerialReceive, .secondary_serial_receive);
  mos_marker_output_selector i_dut (.ref_clk, .arst_n, .markSource, .refMode, .trigRole,
    .gatedOrTriggered, .sampleEn, .waveIsArb, .phaseUpperHalf, .sampleAddr, .cycleStart,
    .patternBit, .waveActive, .lastSeqCycle, .sweepBegin, .sweepEnd, .internalTrig,
    .manualTrig, .remoteTrig, .manualHold, .external_trigger_input, .holdIn, .extRefPresent,
    .sweepPosHit, .editing, .editCursorHit, .serMode, .serAddress, .primarySerialReceive,
    .secondary_serial_receive, .primarySerialTransmit, .secondary_serial_transmit, .txLine,
    .rxLine, .rxChar, .rxCharValid, .txPermit, .addressed, .markerOut, .cursorOut,
    .useExternalRef, .refSocketOe, .refSocketOut, .extTrigEvent, .extGate, .extSweepStart,
    .extSeqAdvance, .lockRestart, .waveHold);
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic watch(input int n);
    {cM, cE, cG, cS, cQ, cL} = 192'h0;
    repeat (n) begin
      @(negedge ref_clk);
      cM += markerOut === 1'h1;
      cE += extTrigEvent === 1'h1;
      cG += extGate === 1'h1;
      cS += extSweepStart === 1'h1;
      cQ += extSeqAdvance === 1'h1;
      cL += lockRestart === 1'h1;
    end
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge ref_clk) rxChar <= c;
    rxCharValid <= 1'h1;
    @(posedge ref_clk) rxCharValid <= 1'h0;
    @(negedge ref_clk);
  endtask
  // marker the rules give for the inputs now standing
  function automatic logic model();
    case (markSource)
      MOS_SRC_PHASE:    return waveIsArb ? sampleAddr < ARB_MARK_POINTS : !phaseUpperHalf;
      MOS_SRC_POSITION: return patternBit;
      MOS_SRC_BURST:    return !(gatedOrTriggered && waveActive);
      MOS_SRC_SEQUENCE: return !lastSeqCycle;
      MOS_SRC_TRIGGER:  return internalTrig | manualTrig | remoteTrig;
      default:          return swSt;
    endcase
  endfunction
  always @(negedge ref_clk) begin
    if (have) chk(markerOut, expM);
    // the marker shows the span flag as it stood before this edge updates it
    expM = model();
    if (sweepBegin) swSt = 1'h1;
    else if (sweepEnd) swSt = 1'h0;
    have = rndOn;
  end
  initial begin
    #9000000;
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h4440));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'h1;
    step(2);
    chk(useExternalRef, 1'h0);
    rndOn = 1'h1;
    // position on a standard wave is left to the directed pulse test
    repeat (400) @(posedge ref_clk) begin
      r = $urandom;
      markSource <= mos_src_t'(r[2:0] % 3'h6);
      waveIsArb <= r[3] || r[2:0] % 3'h6 == 3'h1;
      {phaseUpperHalf, patternBit, gatedOrTriggered, waveActive, lastSeqCycle} <= r[8:4];
      sampleAddr <= {13'h0000, r[11:9]};
      {sweepBegin, sweepEnd, internalTrig} <= r[14:12] & r[17:15];
      {manualTrig, remoteTrig, manualHold, cycleStart, sampleEn} <= r[22:18] & r[27:23];
    end
    @(posedge ref_clk) rndOn = 1'h0;
    {sweepBegin, sweepEnd, internalTrig, manualTrig, remoteTrig, cycleStart} <= 6'h00;
    {sampleEn, waveIsArb} <= 2'h2;
    $display("random marker test finished");
    for (int i = 0; i < 3; i++) begin
      markSource <= i ? MOS_SRC_POSITION : MOS_SRC_LOCK;
      manualHold <= i == 2;
      repeat (4) @(posedge ref_clk);
      cycleStart <= 1'h1;
      @(posedge ref_clk) cycleStart <= 1'h0;
      watch(6);
      chkn(cM, int'(i < 2));
    end
    manualHold <= 1'h0;
    markSource <= MOS_SRC_TRIGGER;
    $display("cycle pulse test finished");
    for (int i = 0; i < 5; i++) begin
      trigRole <= mos_trig_t'(i % 4);
      refMode <= i == 4 ? MOS_REF_LOCK_SLAVE : MOS_REF_INPUT;
      fork
        i_far.pulse(2);
        watch(9);
      join
      chkn(cE, int'(i == 0));
      chkn(cG, 2 * int'(i == 1));
      chkn(cS, int'(i == 2));
      chkn(cQ, int'(i == 3));
      chkn(cL, int'(i == 4));
      if (i == 0) chkn(cM, 1);
    end
    $display("trigger input test finished");
    i_far.set_pins(1'h1, 1'h1);
    for (int m = 0; m < 4; m++) begin
      refMode <= mos_ref_t'(m);
      step(5);
      chk(useExternalRef, m == 0 || m == 3);
      chk(refSocketOe, m == 1 || m == 2);
      chk(refSocketOut, m == 1 || m == 2);
    end
    chk(waveHold, 1'h1);
    i_far.set_pins(1'h0, 1'h0);
    $display("reference and hold test finished");
    send(CHAR_XOFF);
    chk(txPermit, 1'h0);
    send(CHAR_XON);
    chk(txPermit, 1'h1);
    txLine <= 1'h0;
    step(1);
    chk(primarySerialTransmit, 1'h0);
    chk(secondary_serial_transmit, TX_IDLE);
    chk(addressed, 1'h1);
    serMode <= MOS_SER_ADDRESSED;
    send(ADDR_CHAR_MARK | {1'h0, serAddress});
    step(1);
    chk(addressed, 1'h1);
    chk(secondary_serial_transmit, 1'h0);
    send(ADDR_CHAR_MARK | {1'h0, serAddress + 7'h01});
    chk(addressed, 1'h0);
    i_far.set_rx(1'h1, 1'h0);
    step(3);
    chk(rxLine, 1'h0);
    serMode <= MOS_SER_PLAIN;
    step(1);
    chk(rxLine, 1'h1);
    i_far.set_rx(1'h1, 1'h1);
    $display("serial test finished");
    editing <= 1'h1;
    waveIsArb <= 1'h1;
    for (int b = 0; b < 2; b++) begin
      editCursorHit <= b[0];
      step(2);
      chk(cursorOut, b[0]);
    end
    editing <= 1'h0;
    sweepPosHit <= 1'h1;
    sweepEnd <= 1'h1;
    step(1);
    sweepEnd <= 1'h0;
    step(2);
    chk(cursorOut, 1'h0);
    sweepBegin <= 1'h1;
    step(1);
    sweepBegin <= 1'h0;
    step(1);
    chk(cursorOut, 1'h1);
    $display("cursor test finished");
    end_sim;
  end
endmodule
